// *** common/dcu_pkg.sv ***
// constants for the daisy-chain serial path router
// assumes character-level streams from the line receivers/transmitters
// How it works
// (RULE1) every device relays chain traffic, up to 32
// (RULE2) host alone starts every chain transaction
// (RULE3) two-bit routing field selects path configuration
// (RULE4) external loopback: up chain, then back down
// (RULE5) lower receive retransmitted at once from upper
// (RULE6) upper receive resent at once from lower
// (RULE7) single path: down path only buffers, relays
// (RULE8) single path: down-path commands never decoded
// (RULE9) internal loopback feeds upper transmit to receiver
// (RULE10) internal loopback at once ignores upper pins
// (RULE11) host sends loopback enable command twice
// (RULE12) host empties receive buffer before and after
// (RULE13) host moves loopback upward to find breaks
// (RULE14) value 0b10: down path becomes alert interface
// (RULE15) value 0b11: down path independent read path
// (RULE16) non-master path relays writes, never executes them
// (RULE17) rejected write sets sticky flag until cleared
// (RULE18) pass-through characters relayed unchanged, unchecked
package dcu_pkg;
	localparam int DATA_W = 8;
	localparam int FIFO_DEPTH = 16;
	localparam int MAX_CHAIN = 32;
	// fifo headroom kept back for characters already in flight
	localparam int READY_MARGIN = 4;
	localparam logic [1:0] ROUTE_EXT_LOOP = 2'h0;
	localparam logic [1:0] ROUTE_INT_LOOP = 2'h1;
	localparam logic [1:0] ROUTE_ALERT = 2'h2;
	localparam logic [1:0] ROUTE_DUAL = 2'h3;
	localparam logic [1:0] ROUTE_RESET = ROUTE_EXT_LOOP;
	// command byte bit that marks a read-type command when set
	localparam int CMD_READ_BIT = 0;
	localparam logic FLAG_RESET = 1'h0;
endpackage

// *** verilog/dcu_path_router.sv ***
// down-path character fifo and the serial path router
// assumes a protocol core that decodes the exec streams and writes the routing field
`timescale 1ns/10ps

module dcu_fifo #(
	parameter int W = 8,
	parameter int D = 16
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data,
	output logic [$clog2(D+1)-1:0] count
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [$clog2(D+1)-1:0] cnt_q;
	wire push = in_valid & in_ready;
	wire pop = out_valid & out_ready;

	assign in_ready = (cnt_q != D[$clog2(D+1)-1:0]);
	assign out_valid = (cnt_q != '0);
	assign out_data = mem[rd_q];
	assign count = cnt_q;

	always_ff @(posedge clk)
	begin
		if (push)
		begin
			mem[wr_q] <= in_data;
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end
		else
		begin
			if (push)
			begin
				wr_q <= wr_q + 1'b1;
			end
			if (pop)
			begin
				rd_q <= rd_q + 1'b1;
			end
			if (push & ~pop)
			begin
				cnt_q <= cnt_q + 1'b1;
			end
			else if (pop & ~push)
			begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end
endmodule // dcu_fifo

module dcu_path_router (
	input wire logic clk,
	input wire logic reset,
	input wire logic cfg_wr_valid,
	input wire logic [1:0] cfg_wr_value,
	output logic [1:0] path_routing_select,
	input wire logic host_on_down,
	input wire logic reject_flag_clear,
	output logic nonmaster_write_reject_flag,
	input wire logic lower_rx_valid,
	input wire logic lower_rx_sof,
	input wire logic [dcu_pkg::DATA_W-1:0] lower_rx_data,
	output logic lower_rx_ready,
	output logic upper_tx_valid,
	output logic upper_tx_sof,
	output logic [dcu_pkg::DATA_W-1:0] upper_tx_data,
	input wire logic upper_rx_valid,
	input wire logic upper_rx_sof,
	input wire logic [dcu_pkg::DATA_W-1:0] upper_rx_data,
	output logic upper_rx_ready,
	output logic lower_tx_valid,
	output logic lower_tx_sof,
	output logic [dcu_pkg::DATA_W-1:0] lower_tx_data,
	input wire logic lower_tx_ready,
	output logic [1:0] exec_valid,
	output logic [1:0] exec_sof,
	output logic [1:0][dcu_pkg::DATA_W-1:0] exec_data
);
	import dcu_pkg::*;

	localparam int CW = $clog2(FIFO_DEPTH+1);
	localparam logic [CW-1:0] ROOM_LIMIT = CW'(FIFO_DEPTH - READY_MARGIN);

	function automatic logic is_write(input logic [DATA_W-1:0] b);
		return ~b[CMD_READ_BIT];
	endfunction

	logic [1:0] route_q;
	logic flag_q;
	logic lower_rx_ready_q;
	logic upper_rx_ready_q;
	logic up_valid_q;
	logic up_sof_q;
	logic [DATA_W-1:0] up_data_q;
	logic dn_valid_q;
	logic dn_sof_q;
	logic [DATA_W-1:0] dn_data_q;
	logic [1:0] block_q;
	logic [1:0] ex_valid_q;
	logic [1:0] ex_sof_q;
	logic [1:0][DATA_W-1:0] ex_data_q;

	// mode decode
	wire int_loop = (route_q == ROUTE_INT_LOOP);
	wire alert_mode = (route_q == ROUTE_ALERT);
	wire dual = (route_q == ROUTE_DUAL);

	// up path: take from lower receiver
	wire up_take = lower_rx_valid & lower_rx_ready_q;
	// down path source: internal loop or external upper pins
	wire ext_take = upper_rx_valid & upper_rx_ready_q;
	wire dn_src_valid = int_loop ? up_valid_q : (~alert_mode & ext_take); // RULE9 RULE10 RULE14
	wire dn_src_sof = int_loop ? up_sof_q : upper_rx_sof;
	wire [DATA_W-1:0] dn_src_data = int_loop ? up_data_q : upper_rx_data;

	// fifo holds sof bit alongside each character
	wire fifo_in_ready;
	wire fifo_out_valid;
	wire fifo_out_ready = ~dn_valid_q | lower_tx_ready;
	wire [DATA_W:0] fifo_out_data;
	wire [CW-1:0] fifo_count;
	wire dn_push = dn_src_valid & fifo_in_ready;
	wire room = (fifo_count <= ROOM_LIMIT);

	dcu_fifo #(
		.W(DATA_W + 1),
		.D(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.reset(reset),
		.in_valid(dn_src_valid),
		.in_ready(fifo_in_ready),
		.in_data({dn_src_sof, dn_src_data}), // RULE18
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data),
		.count(fifo_count)
	);

	// per-path command screening
	wire [1:0] src_valid = {ext_take & dual, up_take};
	wire [1:0] src_sof = {upper_rx_sof, lower_rx_sof};
	wire [1:0][DATA_W-1:0] src_data = {upper_rx_data, lower_rx_data};
	wire [1:0] nonmaster = {dual & ~host_on_down, dual & host_on_down};
	wire [1:0] reject;
	wire [1:0] deliver;
	wire [1:0] pkt_start = src_valid & src_sof;

	genvar p;
	generate
		for (p = 0; p < 2; p++)
		begin : g_path
			// write on non-master path is relayed but not executed
			assign reject[p] = src_valid[p] & src_sof[p] & nonmaster[p] & is_write(src_data[p]); // RULE16
			assign deliver[p] = src_valid[p] & ~(src_sof[p] ? reject[p] : block_q[p]); // RULE8 RULE15
		end
	endgenerate

	// withhold decision kept until the next command byte
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			block_q <= '0;
			ex_valid_q <= '0;
			ex_sof_q <= '0;
			ex_data_q <= '0;
		end
		else
		begin
			block_q <= reject | (~pkt_start & block_q);
			ex_valid_q <= deliver;
			ex_sof_q <= src_sof;
			ex_data_q <= src_data;
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			route_q <= ROUTE_RESET;
		end
		else if (cfg_wr_valid)
		begin
			route_q <= cfg_wr_value; // RULE3 RULE10
		end
	end

	// sticky flag: a new reject wins over a clear
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			flag_q <= FLAG_RESET;
		end
		else
		begin
			flag_q <= (|reject) | (flag_q & ~reject_flag_clear); // RULE17
		end
	end

	// readies registered; margin covers characters in flight
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			lower_rx_ready_q <= 1'b0;
			upper_rx_ready_q <= 1'b0;
		end
		else
		begin
			lower_rx_ready_q <= ~int_loop | room;
			upper_rx_ready_q <= int_loop | alert_mode | room; // RULE10
		end
	end

	// up relay: retransmit each character next cycle
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			up_valid_q <= 1'b0;
			up_sof_q <= 1'b0;
			up_data_q <= '0;
		end
		else
		begin
			up_valid_q <= up_take; // RULE1 RULE4 RULE5
			up_sof_q <= lower_rx_sof;
			up_data_q <= lower_rx_data;
		end
	end

	// down relay: buffered, unchanged, toward the host
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			dn_valid_q <= 1'b0;
			dn_sof_q <= 1'b0;
			dn_data_q <= '0;
		end
		else if (fifo_out_ready)
		begin
			dn_valid_q <= fifo_out_valid; // RULE6 RULE7
			dn_sof_q <= fifo_out_data[DATA_W];
			dn_data_q <= fifo_out_data[DATA_W-1:0]; // RULE18
		end
	end

	assign path_routing_select = route_q;
	assign nonmaster_write_reject_flag = flag_q;
	assign lower_rx_ready = lower_rx_ready_q;
	assign upper_rx_ready = upper_rx_ready_q;
	assign upper_tx_valid = up_valid_q;
	assign upper_tx_sof = up_sof_q;
	assign upper_tx_data = up_data_q;
	assign lower_tx_valid = dn_valid_q;
	assign lower_tx_sof = dn_sof_q;
	assign lower_tx_data = dn_data_q;
	assign exec_valid = ex_valid_q;
	assign exec_sof = ex_sof_q;
	assign exec_data = ex_data_q;

	a_up_relay_now: assert property (@(posedge clk) disable iff (reset) // RULE5
		up_take |=> upper_tx_valid && upper_tx_data == $past(lower_rx_data))
		else $error("up path character not relayed next cycle");

	a_route_takes_write: assert property (@(posedge clk) disable iff (reset) // RULE3
		cfg_wr_valid |=> path_routing_select == $past(cfg_wr_value))
		else $error("routing field not updated by write");

	a_loop_ignores_pins: assert property (@(posedge clk) disable iff (reset) // RULE10
		int_loop && !up_valid_q |-> !dn_push)
		else $error("upper pins reached down path in internal loopback");

	a_loop_feeds_back: assert property (@(posedge clk) disable iff (reset) // RULE9
		int_loop && up_valid_q |-> dn_push)
		else $error("looped character lost");

	a_alert_no_relay: assert property (@(posedge clk) disable iff (reset) // RULE14
		alert_mode |-> !dn_push)
		else $error("down path relayed in alert mode");

	a_single_no_exec: assert property (@(posedge clk) disable iff (reset) // RULE8
		!$past(dual) |-> !exec_valid[1])
		else $error("down path command decoded in single path mode");

	a_dual_read_exec: assert property (@(posedge clk) disable iff (reset) // RULE15
		dual && ext_take && upper_rx_sof && !is_write(upper_rx_data) |=> exec_valid[1])
		else $error("read on down path not processed");

	a_nonmaster_no_write: assert property (@(posedge clk) disable iff (reset) // RULE16
		dual && !host_on_down && ext_take && upper_rx_sof && is_write(upper_rx_data)
		|=> !exec_valid[1] && nonmaster_write_reject_flag)
		else $error("non-master write executed or not flagged");

	a_flag_sticky: assert property (@(posedge clk) disable iff (reset) // RULE17
		nonmaster_write_reject_flag && !reject_flag_clear |=> nonmaster_write_reject_flag)
		else $error("reject flag dropped without clear");

	a_fifo_no_drop: assert property (@(posedge clk) disable iff (reset) // RULE7
		dn_src_valid |-> fifo_in_ready)
		else $error("down path character dropped at full fifo");
endmodule // dcu_path_router

// *** test/dcu_far_model.sv ***
// far side: loopback cable at the chain top and the lower transmitter's ready
// assumes the bench drives hold to stall the lower transmitter
`timescale 1ns/10ps

module dcu_far_model (
	input wire logic clk,
	input wire logic hold,
	input wire logic upper_tx_valid,
	input wire logic upper_tx_sof,
	input wire logic [dcu_pkg::DATA_W-1:0] upper_tx_data,
	output logic upper_rx_valid,
	output logic upper_rx_sof,
	output logic [dcu_pkg::DATA_W-1:0] upper_rx_data,
	output logic lower_tx_ready
);
	import dcu_pkg::*;
	logic [2:0] phase_q;

	initial
	begin
		phase_q = 3'h0;
		upper_rx_valid = 1'h0;
		upper_rx_sof = 1'h0;
		upper_rx_data = 8'h00;
		lower_tx_ready = 1'h0;
	end

	// echo only, never originates; idle line shows inverted garbage
	always @(posedge clk)
	begin
		phase_q <= phase_q + 3'h1;
		upper_rx_valid <= upper_tx_valid;
		upper_rx_sof <= upper_tx_valid ? upper_tx_sof : ~upper_rx_sof;
		upper_rx_data <= upper_tx_valid ? upper_tx_data : ~upper_rx_data;
		lower_tx_ready <= !hold && phase_q[2:1] != 2'h3;
	end
endmodule // dcu_far_model

// *** test/dcu_path_router_tb.sv ***
// bench for the path router: queue model checked at every output character
// assumes dcu_pkg and dcu_far_model are compiled first
`timescale 1ns/10ps

module dcu_path_router_tb;
	import dcu_pkg::*;
	logic clk = 0, reset = 1, cfg_wr_valid = 0, host_on_down = 0, reject_flag_clear = 0, hold = 0;
	logic lower_rx_valid = 0, lower_rx_sof = 0, lower_rx_ready, upper_tx_valid, upper_tx_sof;
	logic upper_rx_valid, upper_rx_sof, upper_rx_ready, lower_tx_valid, lower_tx_sof, lower_tx_ready;
	logic nonmaster_write_reject_flag, w0 = 0, w1 = 0, exp_flag = 0, seen_full = 0;
	logic [1:0] cfg_wr_value = 0, path_routing_select, exec_valid, exec_sof, mode = 0;
	logic [DATA_W-1:0] lower_rx_data = 0, upper_tx_data, upper_rx_data, lower_tx_data;
	logic [1:0][DATA_W-1:0] exec_data;
	logic [DATA_W:0] up_q[$], dn_q[$], ex0_q[$], ex1_q[$];
	int miscompares = 0, checks_done = 0, cyc = 0, seed = 70;

	always #2 clk = ~clk;

	dcu_path_router dcu_path_router_inst (.clk(clk), .reset(reset), .cfg_wr_valid(cfg_wr_valid),
		.cfg_wr_value(cfg_wr_value), .path_routing_select(path_routing_select), .host_on_down(host_on_down),
		.reject_flag_clear(reject_flag_clear), .nonmaster_write_reject_flag(nonmaster_write_reject_flag),
		.lower_rx_valid(lower_rx_valid), .lower_rx_sof(lower_rx_sof), .lower_rx_data(lower_rx_data),
		.lower_rx_ready(lower_rx_ready), .upper_tx_valid(upper_tx_valid), .upper_tx_sof(upper_tx_sof),
		.upper_tx_data(upper_tx_data), .upper_rx_valid(upper_rx_valid), .upper_rx_sof(upper_rx_sof),
		.upper_rx_data(upper_rx_data), .upper_rx_ready(upper_rx_ready), .lower_tx_valid(lower_tx_valid),
		.lower_tx_sof(lower_tx_sof), .lower_tx_data(lower_tx_data), .lower_tx_ready(lower_tx_ready),
		.exec_valid(exec_valid), .exec_sof(exec_sof), .exec_data(exec_data));

	dcu_far_model dcu_far_model_inst (.clk(clk), .hold(hold), .upper_tx_valid(upper_tx_valid),
		.upper_tx_sof(upper_tx_sof), .upper_tx_data(upper_tx_data), .upper_rx_valid(upper_rx_valid),
		.upper_rx_sof(upper_rx_sof), .upper_rx_data(upper_rx_data), .lower_tx_ready(lower_tx_ready));

	task chk(input string what, input logic [DATA_W:0] e, input logic [DATA_W:0] g);
		checks_done++;
		if (e !== g)
		begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, e, g);
		end
	endtask

	task summarize;
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// model sees pre-edge values, as the design does
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			miscompares++;
			summarize;
		end
		if (!reset)
		begin
			if (lower_rx_valid && lower_rx_ready)
			begin
				w0 = lower_rx_sof ? !lower_rx_data[CMD_READ_BIT] : w0;
				up_q.push_back({lower_rx_sof, lower_rx_data});
				if (mode == ROUTE_DUAL && host_on_down && w0)
					exp_flag = exp_flag | lower_rx_sof;
				else
					ex0_q.push_back({lower_rx_sof, lower_rx_data});
			end
			if (upper_rx_valid && upper_rx_ready && (mode == ROUTE_EXT_LOOP || mode == ROUTE_DUAL))
			begin
				w1 = upper_rx_sof ? !upper_rx_data[CMD_READ_BIT] : w1;
				dn_q.push_back({upper_rx_sof, upper_rx_data});
				if (mode == ROUTE_DUAL && !host_on_down && w1)
					exp_flag = exp_flag | upper_rx_sof;
				else if (mode == ROUTE_DUAL)
					ex1_q.push_back({upper_rx_sof, upper_rx_data});
			end
			if (upper_tx_valid && mode == ROUTE_INT_LOOP)
				dn_q.push_back({upper_tx_sof, upper_tx_data});
			if (upper_tx_valid)
				chk("up", up_q.size() ? up_q.pop_front() : 'x, {upper_tx_sof, upper_tx_data});
			if (lower_tx_valid && lower_tx_ready)
				chk("down", dn_q.size() ? dn_q.pop_front() : 'x, {lower_tx_sof, lower_tx_data});
			if (exec_valid[0])
				chk("exec0", ex0_q.size() ? ex0_q.pop_front() : 'x, {exec_sof[0], exec_data[0]});
			if (exec_valid[1])
				chk("exec1", ex1_q.size() ? ex1_q.pop_front() : 'x, {exec_sof[1], exec_data[1]});
			if (upper_rx_valid)
				chk("upper_ready", 9'h1, {8'h0, upper_rx_ready});
			if (lower_rx_valid && mode != ROUTE_INT_LOOP)
				chk("lower_ready", 9'h1, {8'h0, lower_rx_ready});
			if (reject_flag_clear)
				exp_flag = 0;
			if (!lower_rx_ready && mode == ROUTE_INT_LOOP)
				seen_full = 1;
			if (cfg_wr_valid)
				mode = cfg_wr_value;
		end
	end

	task send(input logic s, input logic [DATA_W-1:0] d);
		lower_rx_valid <= 1'h1;
		lower_rx_sof <= s;
		lower_rx_data <= d;
		do
			@(posedge clk);
		while (lower_rx_ready !== 1'b1);
	endtask

	task pkt(input logic rd, input int n);
		logic [DATA_W-1:0] c;
		c = DATA_W'($random(seed));
		c[CMD_READ_BIT] = rd;
		send(1'h1, c);
		repeat (n) send(1'h0, DATA_W'($random(seed)));
	endtask

	task route(input logic [1:0] v);
		cfg_wr_valid <= 1'h1;
		cfg_wr_value <= v;
		@(posedge clk);
		cfg_wr_valid <= 1'h0;
		@(posedge clk);
		chk("routing", {7'h0, v}, {7'h0, path_routing_select});
	endtask

	task settle;
		repeat (8) @(posedge clk);
		while (up_q.size() + dn_q.size() + ex0_q.size() + ex1_q.size() != 0) @(posedge clk);
		repeat (8) @(posedge clk);
		chk("flag", {8'h0, exp_flag}, {8'h0, nonmaster_write_reject_flag});
	endtask

	initial
	begin
		repeat (6) @(posedge clk);
		reset <= 1'h0;
		@(posedge clk);
		chk("routing", {7'h0, ROUTE_RESET}, {7'h0, path_routing_select});
		for (int k = 0; k < 5; k++)
		begin
			host_on_down <= k == 3;
			settle;
			route(k < 2 ? 2'(2 * k) : (k < 4 ? ROUTE_DUAL : ROUTE_INT_LOOP));
			if (k == 4)
				route(ROUTE_INT_LOOP);
			hold <= k == 4;
			fork
				begin
					pkt(1'h0, 3);
					pkt(1'h1, 2);
					pkt(1'h0, 18);
					lower_rx_valid <= 1'h0;
				end
				begin
					repeat (120) @(posedge clk);
					hold <= 1'h0;
				end
			join
			settle;
			reject_flag_clear <= 1'h1;
			@(posedge clk);
			reject_flag_clear <= 1'h0;
			settle;
		end
		chk("refused", 9'h1, {8'h0, seen_full});
		// loopback moved one device up: relay must pass through again
		route(ROUTE_EXT_LOOP);
		pkt(1'h1, 4);
		lower_rx_valid <= 1'h0;
		settle;
		summarize;
	end
endmodule // dcu_path_router_tb
